/* File: rtl/djkf_top.sv */
module djkf_top
	import djkf_pkg::*;
(
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst,
	// variant select, high selects edge-triggered behaviour
	input wire logic i_mode_edge,
	// shared element pins
	input wire logic i_jk_clk,
	input wire logic i_async_zero_n,
	// per-element pins
	input wire logic [DJKF_NUM_ELEM-1:0] i_preset_n,
	input wire logic [DJKF_NUM_ELEM-1:0] i_j,
	input wire logic [DJKF_NUM_ELEM-1:0] i_k,
	// element outputs
	output logic [DJKF_NUM_ELEM-1:0] o_q,
	output logic [DJKF_NUM_ELEM-1:0] o_q_n
);

	function automatic logic djkf_jk_next(input logic q, input logic j, input logic k);
		unique case ({j, k})
			2'b00: djkf_jk_next = q;
			2'b10: djkf_jk_next = 1'b1;
			2'b01: djkf_jk_next = 1'b0;
			2'b11: djkf_jk_next = ~q;
		endcase
	endfunction : djkf_jk_next

	// an element is under override while its own preset or the shared clear is low
	function automatic logic djkf_forced(input logic preset_n, input logic zero_n);
		djkf_forced = !preset_n || !zero_n;
	endfunction : djkf_forced

	// both low is the unstable case that drives the true and complement outputs high together
	function automatic logic djkf_both_low(input logic preset_n, input logic zero_n);
		djkf_both_low = !preset_n && !zero_n;
	endfunction : djkf_both_low

	logic [DJKF_SYNC_W-1:0] raw_pins;
	logic [DJKF_SYNC_W-1:0] pins;
	logic clk_f;
	logic zero_n_f;
	logic [DJKF_NUM_ELEM-1:0] preset_n_f;
	logic [DJKF_NUM_ELEM-1:0] j_f;
	logic [DJKF_NUM_ELEM-1:0] k_f;
	logic clk_prev;
	logic clk_fall;
	logic mode_s1;
	logic mode_s2;
	logic mode_s3;
	djkf_mode_t mode;
	logic [DJKF_NUM_ELEM-1:0] master;
	logic [DJKF_NUM_ELEM-1:0] state;
	logic [DJKF_NUM_ELEM-1:0] next_state;
	logic [DJKF_NUM_ELEM-1:0] next_master;
	logic [DJKF_NUM_ELEM-1:0] next_q_n;
	logic [DJKF_NUM_ELEM-1:0] next_q;
	logic [DJKF_NUM_ELEM-1:0] forced;
	logic [DJKF_NUM_ELEM-1:0] both_low;

	assign raw_pins = {i_k, i_j, i_preset_n, i_async_zero_n, i_jk_clk};

	// clock, clear, preset, j and k share one filter so levels that change together stay together
	djkf_sync u_sync
	(
		.i_ref_clk(i_ref_clk),
		.i_rst(i_rst),
		.i_pins(raw_pins),
		.o_pins(pins)
	);

	assign clk_f = pins[DJKF_POS_CLK];
	assign zero_n_f = pins[DJKF_POS_ZERO_N];
	assign preset_n_f = pins[DJKF_POS_PRESET_N +: DJKF_NUM_ELEM];
	assign j_f = pins[DJKF_POS_J +: DJKF_NUM_ELEM];
	assign k_f = pins[DJKF_POS_K +: DJKF_NUM_ELEM];

	// the mode pin is a strap-like level, so it gets the same three-stage treatment
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			mode_s1 <= DJKF_MODE_RST;
			mode_s2 <= DJKF_MODE_RST;
			mode_s3 <= DJKF_MODE_RST;
		end
		else
		begin
			mode_s1 <= i_mode_edge;
			mode_s2 <= mode_s1;
			mode_s3 <= mode_s2;
		end
	end

	// a mode change is taken at once, so a switch in mid-pulse applies the new rule at the next fall
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
			mode <= DJKF_MODE_RST;
		else if (mode_s2 == mode_s3)
			mode <= djkf_mode_t'(mode_s3);
	end

	// resets low like an idle clock pin, so no false fall follows reset
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
			clk_prev <= DJKF_CLK_PREV_RST;
		else
			clk_prev <= clk_f;
	end

	// one cycle wide, since the filtered clock cannot bounce between two edges
	assign clk_fall = clk_prev & ~clk_f;

	// preset and clear are sampled like every pin, so their override lags the pins by the filter latency
	always_comb
	begin
		forced = '0;
		both_low = '0;
		for (int e = 0; e < DJKF_NUM_ELEM; e++)
		begin
			forced[e] = djkf_forced(preset_n_f[e], zero_n_f);
			both_low[e] = djkf_both_low(preset_n_f[e], zero_n_f);
		end
	end

	// in edge mode the master shadows the state, so a switch to pulse mode starts from the held value
	always_comb
	begin
		next_master = master;
		for (int e = 0; e < DJKF_NUM_ELEM; e++)
		begin
			if (both_low[e])
				next_master[e] = 1'b0;
			else if (forced[e])
				next_master[e] = ~preset_n_f[e];
			else if (mode == DJKF_EDGE)
				next_master[e] = state[e];
			else if (clk_f)
				next_master[e] = djkf_jk_next(state[e], j_f[e], k_f[e]);
		end
	end

	// both asserted stores a low state, so the forced-high pair is not kept once they return high
	always_comb
	begin
		next_state = state;
		for (int e = 0; e < DJKF_NUM_ELEM; e++)
		begin
			if (both_low[e])
				next_state[e] = 1'b0;
			else if (forced[e])
				next_state[e] = ~preset_n_f[e];
			else if (clk_fall)
			begin
				if (mode == DJKF_PULSE)
					next_state[e] = master[e];
				else
					next_state[e] = djkf_jk_next(state[e], j_f[e], k_f[e]);
			end
		end
	end

	always_comb
	begin
		next_q = next_state;
		next_q_n = ~next_state;
		for (int e = 0; e < DJKF_NUM_ELEM; e++)
		begin
			if (both_low[e])
			begin
				next_q[e] = 1'b1;
				next_q_n[e] = 1'b1;
			end
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
			state <= {DJKF_NUM_ELEM{DJKF_Q_RST}};
		else
			state <= next_state;
	end

	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
			master <= {DJKF_NUM_ELEM{DJKF_MASTER_RST}};
		else
			master <= next_master;
	end

	// outputs get flops of their own so the pins never show the combinational override path
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
			o_q <= {DJKF_NUM_ELEM{DJKF_Q_RST}};
		else
			o_q <= next_q;
	end

	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
			o_q_n <= {DJKF_NUM_ELEM{DJKF_Q_N_RST}};
		else
			o_q_n <= next_q_n;
	end

endmodule : djkf_top

/* File: rtl/djkf_pkg.sv */
package djkf_pkg;

	// timing variant of both storage elements
	typedef enum logic
	{
		DJKF_PULSE = 1'b0,
		DJKF_EDGE = 1'b1
	} djkf_mode_t;

	localparam int DJKF_NUM_ELEM = 2;
	localparam int DJKF_SYNC_W = 8;

	// bit positions of the synchronised pin bundle
	localparam int DJKF_POS_CLK = 0;
	localparam int DJKF_POS_ZERO_N = 1;
	localparam int DJKF_POS_PRESET_N = 2;
	localparam int DJKF_POS_J = 4;
	localparam int DJKF_POS_K = 6;

	// value of the bundle after reset: clock low, preset and clear idle, j and k low
	localparam logic [DJKF_SYNC_W-1:0] DJKF_SYNC_RST = 8'h0e;

	localparam logic DJKF_Q_RST = 1'b0;
	localparam logic DJKF_Q_N_RST = 1'b1;
	localparam logic DJKF_MASTER_RST = 1'b0;
	localparam logic DJKF_CLK_PREV_RST = 1'b0;
	localparam djkf_mode_t DJKF_MODE_RST = DJKF_PULSE;

endpackage : djkf_pkg

/* File: rtl/djkf_sync.sv */
module djkf_sync
	import djkf_pkg::*;
(
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst,
	// raw pins
	input wire logic [DJKF_SYNC_W-1:0] i_pins,
	// filtered pins
	output logic [DJKF_SYNC_W-1:0] o_pins
);

	logic [DJKF_SYNC_W-1:0] stage1;
	logic [DJKF_SYNC_W-1:0] stage2;
	logic [DJKF_SYNC_W-1:0] stage3;

	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			stage1 <= DJKF_SYNC_RST;
			stage2 <= DJKF_SYNC_RST;
			stage3 <= DJKF_SYNC_RST;
		end
		else
		begin
			stage1 <= i_pins;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// a bit only moves once the last two stages agree, which filters one-cycle glitches
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
			o_pins <= DJKF_SYNC_RST;
		else
		begin
			for (int b = 0; b < DJKF_SYNC_W; b++)
			begin
				if (stage2[b] == stage3[b])
					o_pins[b] <= stage3[b];
			end
		end
	end

endmodule : djkf_sync

/* File: verification/djkf_far.sv */
module djkf_far
(
	input wire logic i_ref_clk,
	input wire logic i_go,
	input wire logic [3:0] i_jk,
	output logic o_jk_clk,
	output logic [3:0] o_jk = 4'h0
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt = 4'h0;
	assign o_jk_clk = |cnt;
	always @(posedge i_ref_clk)
		cnt <= i_go ? 4'h9 : cnt - {3'h0, o_jk_clk};
	// j and k move only as a pulse starts, never while the clock is high
	always @(posedge i_ref_clk)
		if (i_go)
			o_jk <= i_jk;
endmodule : djkf_far

/* File: verification/djkf_top_assertions.sv */
module djkf_chk
	import djkf_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_jk_clk,
	input wire logic i_async_zero_n,
	input wire logic [1:0] i_preset_n,
	input wire logic [1:0] i_j,
	input wire logic [1:0] i_k,
	input wire logic [1:0] o_q,
	input wire logic [1:0] o_q_n
);
	default clocking @(posedge i_ref_clk);
	endclocking
	default disable iff (i_rst);
	wire h = i_jk_clk;
	wire p = i_preset_n[0];
	wire c = i_async_zero_n;
	wire s = p & c & i_j[0] & !i_k[0];
	wire t = p & c & i_j[0] & i_k[0];
	// six samples outlast the four-edge pin filter plus the output flop
	AST_PRE: assert property ((!p && c)[*6] |-> o_q[0]) else $error("preset");
	AST_CLR: assert property ((p && !c)[*6] |-> !o_q[0]) else $error("clear");
	AST_BOTH: assert property ((!p && !c)[*6] |-> o_q[0] && o_q_n[0]) else $error("both");
	AST_CMP: assert property ((&i_preset_n && c)[*6] |-> &(o_q ^ o_q_n)) else $error("compl");
	AST_HI: assert property ((p && c && h)[*8] |-> $stable(o_q[0])) else $error("high");
	AST_LO: assert property ((p && c && !h)[*8] |-> $stable(o_q[0])) else $error("low");
	AST_SET: assert property ((s && h)[*3] ##1 (s && !h)[*6] |-> o_q[0]) else $error("set");
	AST_TOG: assert property ((t && h)[*3] ##1 (t && !h)[*6] |-> o_q[0] != $past(o_q[0], 6)) else $error("tog");
	cover property (!p && !c);
	cover property (s && h);
	cover property (t && h);
endmodule : djkf_chk
bind djkf_top djkf_chk djkf_chk_inst
(
	.i_ref_clk(i_ref_clk),
	.i_rst(i_rst),
	.i_jk_clk(i_jk_clk),
	.i_async_zero_n(i_async_zero_n),
	.i_preset_n(i_preset_n),
	.i_j(i_j),
	.i_k(i_k),
	.o_q(o_q),
	.o_q_n(o_q_n)
);

/* File: verification/tb_djkf_top.sv */
module tb_djkf_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_ref_clk = 1'b0, i_rst = 1'b1, i_mode_edge = 1'b0, i_async_zero_n = 1'b1, go = 1'b0, i_jk_clk;
	logic [1:0] i_preset_n = 2'h3, i_j, i_k, o_q, o_q_n;
	logic [3:0] jk = 4'h0;
	int bad_count = 0, total_checks = 0;
	always #2.5 i_ref_clk = ~i_ref_clk;
	djkf_far djkf_far_inst (.i_ref_clk, .i_go(go), .i_jk(jk), .o_jk_clk(i_jk_clk), .o_jk({i_j, i_k}));
	djkf_top djkf_top_inst
	(
		.i_ref_clk(i_ref_clk),
		.i_rst(i_rst),
		.i_mode_edge(i_mode_edge),
		.i_jk_clk(i_jk_clk),
		.i_async_zero_n(i_async_zero_n),
		.i_preset_n(i_preset_n),
		.i_j(i_j),
		.i_k(i_k),
		.o_q(o_q),
		.o_q_n(o_q_n)
	);
	task run(input logic [2:0] pc, input logic [3:0] jv, input logic [3:0] e);
		{i_preset_n, i_async_zero_n} <= pc;
		jk <= jv;
		go <= 1'b1;
		@(posedge i_ref_clk);
		go <= 1'b0;
		repeat (18) @(posedge i_ref_clk);
		total_checks++;
		if ({o_q, o_q_n} !== e)
		begin
			bad_count++;
			$display("Error q expected %h seen %h", e, {o_q, o_q_n});
		end
	endtask : run
	task t_async;
		run(3'h5, 4'h0, 4'h6);
		run(3'h3, 4'h0, 4'hc);
		run(3'h6, 4'hc, 4'h3);
		run(3'h0, 4'h0, 4'hf);
		run(3'h7, 4'h0, 4'h3);
		$display("async done");
	endtask : t_async
	task t_jk(input logic m);
		i_mode_edge <= m;
		run(3'h7, 4'h6, 4'h6);
		run(3'h7, 4'h0, 4'h6);
		run(3'h7, 4'hf, 4'h9);
		run(3'h7, 4'h3, 4'h3);
		$display("jk done");
	endtask : t_jk
	task end_sim;
		$display("%0d checks, %0d bad", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_sim
	initial
	begin
		repeat (500) @(posedge i_ref_clk);
		bad_count++;
		end_sim;
	end
	initial
	begin
		repeat (16) @(posedge i_ref_clk);
		i_rst <= 1'b0;
		@(posedge i_ref_clk);
		t_async;
		t_jk(1'b0);
		t_jk(1'b1);
		end_sim;
	end
endmodule : tb_djkf_top
